// ===== bench/port_pm_cap_monitor.sv
// Port checks for the power management capability block
`timescale 1ns/1ps
module port_pm_cap_monitor #(
	parameter bit UPSTREAM = 1'b0,
	parameter int unsigned HOT_RESET_LEN = 4
)
(
	// Clock and resets
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic soft_reset_i,
	// Access
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic cfg_rvalid_o,
	// State
	input wire logic [1:0] power_state_o,
	input wire logic wake_enable_o,
	input wire logic hot_reset_o,
	input wire logic internal_reset_o,
	input wire logic downstream_reset_out_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	localparam logic [20:0] PM_LOW = {5'h03, (UPSTREAM ? 8'h5C : 8'h4C), 8'h01};
	localparam logic [15:0] MSG_LOW = UPSTREAM ? 16'h0000 : 16'h6405;
	logic [7:0] run_len;
	logic [7:0] next_run_len;
	logic ps_wr;
	logic [1:0] wr_ps;
	assign ps_wr = cfg_wr_i && cfg_addr_i == 8'h44 && cfg_be_i[0] && !soft_reset_i && !hot_reset_o;
	assign wr_ps = cfg_wdata_i[1:0];
	always_comb next_run_len = hot_reset_o ? run_len + 8'h01 : 8'h00;
	always_ff @(posedge core_clk_i or negedge resetn_i)
		if (!resetn_i)
			run_len <= 8'h00;
		else
			run_len <= next_run_len;
	sequence leave_d3;
		power_state_o == 2'h3 && ps_wr && wr_ps == 2'h0;
	endsequence
	a_rd_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
		else $error("read not answered");
	a_pm_header: assert property (cfg_rd_i && cfg_addr_i == 8'h40 |=> cfg_rdata_o[20:0] == PM_LOW)
		else $error("pm header wrong");
	a_msg_header: assert property (cfg_rd_i && cfg_addr_i == 8'h4C |=> cfg_rdata_o[15:0] == MSG_LOW)
		else $error("interrupt capability header wrong");
	a_rvalid_once: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
		else $error("read valid without read");
	a_state_write: assert property (ps_wr |=> power_state_o == $past(wr_ps))
		else $error("power state not written");
	a_soft_clear: assert property (soft_reset_i |=> power_state_o == 2'h0 && $stable(wake_enable_o))
		else $error("soft reset effect wrong");
	a_hot_start: assert property (leave_d3 |=> !hot_reset_o ##1 hot_reset_o)
		else $error("hot reset not started");
	a_hot_length: assert property ($fell(hot_reset_o) |-> run_len == 8'(HOT_RESET_LEN))
		else $error("hot reset length wrong");
	a_int_in_hot: assert property (internal_reset_o |-> hot_reset_o)
		else $error("internal reset outside hot reset");
	a_dn_quiet: assert property (downstream_reset_out_n_o)
		else $error("downstream reset asserted");
endmodule

bind port_power_mgmt_capability port_pm_cap_monitor #(.UPSTREAM(UPSTREAM), .HOT_RESET_LEN(HOT_RESET_LEN)) mon (
	.core_clk_i, .resetn_i, .soft_reset_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i,
	.cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .power_state_o, .wake_enable_o,
	.hot_reset_o, .internal_reset_o, .downstream_reset_out_n_o
);

// ===== bench/port_power_mgmt_capability_tb.sv
// Self-checking bench for the port power management capability block
`timescale 1ns/1ps
module port_power_mgmt_capability_tb;
	logic core_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [3:0] cfg_be_i = 4'h0;
	logic [31:0] cfg_wdata_i = 32'h00000000;
	logic [31:0] cfg_rdata_o;
	logic cfg_rvalid_o;
	logic defaults_load_i = 1'b0;
	port_pm_cap_pkg::cap_defaults_s defaults_i = port_pm_cap_pkg::CAP_DEFAULTS_RESET;
	logic [1:0] power_state_o;
	logic wake_enable_o;
	logic hot_reset_o;
	logic internal_reset_o;
	logic downstream_reset_out_n_o;
	logic [31:0] cfg_rdata_up;
	logic [1:0] power_state_up;
	logic hot_reset_up;
	port_pm_cap_pkg::cap_defaults_s m = port_pm_cap_pkg::CAP_DEFAULTS_RESET;
	logic [1:0] ps = 2'h0;
	logic we = 1'b0;
	logic [3:0] ds = 4'h0;
	logic [7:0] addrs [5] = '{8'h34, 8'h40, 8'h44, 8'h4C, 8'h48};
	int miscompares = 0;
	int checked = 0;

	always #2 core_clk_i = ~core_clk_i;

	port_power_mgmt_capability #(.UPSTREAM(1'b0), .HOT_RESET_LEN(4)) dut (
		.core_clk_i, .resetn_i, .soft_reset_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i,
		.cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .defaults_load_i, .defaults_i,
		.power_state_o, .wake_enable_o, .hot_reset_o, .internal_reset_o, .downstream_reset_out_n_o
	);

	port_power_mgmt_capability #(.UPSTREAM(1'b1), .HOT_RESET_LEN(4)) dut_up (
		.core_clk_i, .resetn_i, .soft_reset_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i,
		.cfg_wdata_i, .cfg_rdata_o(cfg_rdata_up), .cfg_rvalid_o(), .defaults_load_i, .defaults_i,
		.power_state_o(power_state_up), .wake_enable_o(), .hot_reset_o(hot_reset_up),
		.internal_reset_o(), .downstream_reset_out_n_o()
	);

	function automatic logic [31:0] exp_word(input logic [7:0] a, input logic up);
		case (a)
			8'h34: return 32'h00000040;
			8'h40: return {m.wake_support, m.d2_support, m.d1_support, m.aux_current, m.dev_init,
				5'h03, (up ? 8'h5C : 8'h4C), 8'h01};
			8'h44: return {m.data_byte, 11'h000, ds, we, 4'h0, m.no_soft_reset, 1'b0, ps};
			8'h4C: return up ? 32'h00000000 : 32'h00006405;
			default: return 32'h00000000;
		endcase
	endfunction

	task automatic give_verdict();
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_all();
		logic [31:0] mask;
		foreach (addrs[i])
		begin
			@(negedge core_clk_i);
			cfg_rd_i = 1'b1;
			cfg_addr_i = addrs[i];
			@(negedge core_clk_i);
			cfg_rd_i = 1'b0;
			mask = (addrs[i] == 8'h4C) ? 32'h0000FFFF : 32'hFFFFFFFF;
			chk("cfg_rvalid_o", 32'h1, 32'(cfg_rvalid_o));
			chk("cfg_rdata_o", exp_word(addrs[i], 1'b0), cfg_rdata_o & mask);
			chk("cfg_rdata_up", exp_word(addrs[i], 1'b1), cfg_rdata_up & mask);
		end
		chk("power_state_o", 32'(ps), 32'(power_state_o));
		chk("power_state_up", 32'(ps), 32'(power_state_up));
		chk("wake_enable_o", 32'(we), 32'(wake_enable_o));
		chk("downstream_reset_out_n_o", 32'h1, 32'(downstream_reset_out_n_o));
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge core_clk_i);
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_be_i = be;
		cfg_wdata_i = d;
		@(negedge core_clk_i);
		cfg_wr_i = 1'b0;
		if (a == 8'h44 && be[0] && !soft_reset_i)
			ps = d[1:0];
		if (a == 8'h44 && be[1] && !soft_reset_i)
			{ds, we} = d[12:8];
	endtask

	task automatic load(input port_pm_cap_pkg::cap_defaults_s c);
		@(negedge core_clk_i);
		defaults_i = c;
		defaults_load_i = 1'b1;
		@(negedge core_clk_i);
		defaults_load_i = 1'b0;
		m = c;
	endtask

	initial
	begin
		void'($urandom(32'h0ADC));
		repeat (4) @(negedge core_clk_i);
		resetn_i = 1'b1;
		rd_all();
		for (int i = 0; i < 8; i++)
		begin
			load(20'($urandom));
			wr(8'h40, 4'hF, $urandom);
			wr(8'h44, 4'($urandom), $urandom | 32'h00000001);
			rd_all();
		end
		wr(8'h44, 4'h2, 32'h00000100);
		soft_reset_i = 1'b1;
		wr(8'h44, 4'h3, 32'h00001E03);
		soft_reset_i = 1'b0;
		ps = 2'h0;
		ds = 4'h0;
		rd_all();
		for (int k = 0; k < 2; k++)
		begin
			load({m[19:9], k[0], m[7:0]});
			for (int s = 1; s < 4; s++)
				wr(8'h44, 4'h3, 32'(s) | ($urandom & 32'h00001F00));
			wr(8'h44, 4'h1, 32'h00000000);
			for (int i = 0; i < 6; i++)
			begin
				chk("hot_reset_o", 32'(i > 0 && i < 5), 32'(hot_reset_o));
				chk("internal_reset_o", 32'(i > 0 && i < 5 && !k[0]), 32'(internal_reset_o));
				chk("hot_reset_up", 32'(i > 0 && i < 5), 32'(hot_reset_up));
				@(negedge core_clk_i);
			end
			if (!k[0])
				ds = 4'h0;
			rd_all();
		end
		give_verdict();
	end

	initial
	begin
		#20000;
		miscompares++;
		give_verdict();
	end
endmodule

// ===== rtl/pm_reset_pulse.sv
// Fixed-length pulse generator for the power-state hot reset
`timescale 1ns/1ps
module pm_reset_pulse #(
	parameter int unsigned LENGTH = 4
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Trigger and pulse
	input wire logic start_i,
	output logic pulse_o
);

	logic [7:0] count;
	logic [7:0] next_count;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_comb
	begin
		next_count = count;
		if (start_i)
		begin
			next_count = 8'(LENGTH);
		end
		else if (count != 8'h00)
		begin
			next_count = count - 8'h01;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			count <= 8'h00;
		end
		else
		begin
			count <= next_count;
		end
	end

	assign pulse_o = (count != 8'h00);

endmodule

// ===== rtl/port_pm_cap_pkg.sv
// Shared constants and types for the port power management capability block
package port_pm_cap_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
	localparam logic [7:0] PM_CAP_OFFSET = 8'h40;
	localparam logic [7:0] PM_CSR_OFFSET = 8'h44;
	localparam logic [7:0] MSG_CAP_OFFSET = 8'h4C;

	// ------------------------------------------------------------
	// Fixed values and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CAP_PTR_RESET = 8'h40;
	localparam logic [7:0] PM_CAP_ID = 8'h01;
	localparam logic [7:0] PM_NEXT_UP = 8'h5C;
	localparam logic [7:0] PM_NEXT_DN = 8'h4C;
	localparam logic [2:0] PM_REVISION = 3'h3;
	localparam logic [7:0] MSG_CAP_ID = 8'h05;
	localparam logic [7:0] MSG_NEXT = 8'h64;
	localparam logic [2:0] AUX_CURRENT_RESET = 3'h7;
	localparam logic [4:0] WAKE_SUPPORT_RESET = 5'h1F;
	localparam logic [7:0] DATA_BYTE_RESET = 8'h00;
	localparam logic [3:0] DATA_SELECT_RESET = 4'h0;
	localparam logic [2:0] HOT_RESET_CYCLES = 3'h4;

	// ------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------
	localparam logic [1:0] PSTATE_D0 = 2'h0;
	localparam logic [1:0] PSTATE_D3HOT = 2'h3;

	// Loadable advertised capability fields
	typedef struct packed {
		logic dev_init;
		logic [2:0] aux_current;
		logic d1_support;
		logic d2_support;
		logic [4:0] wake_support;
		logic no_soft_reset;
		logic [7:0] data_byte;
	} cap_defaults_s;

	localparam cap_defaults_s CAP_DEFAULTS_RESET = '{
		dev_init: 1'b0,
		aux_current: AUX_CURRENT_RESET,
		d1_support: 1'b1,
		d2_support: 1'b1,
		wake_support: WAKE_SUPPORT_RESET,
		no_soft_reset: 1'b1,
		data_byte: DATA_BYTE_RESET
	};

endpackage

// ===== rtl/port_power_mgmt_capability.sv
// Power management and message interrupt capability registers of one port
// How it works
// - Power_mgmt_capability_header id reads 01h
// - Next pointer 5Ch upstream, 4Ch downstream
// - PM revision field reads 011b
// - Bits 19, 20 read zero; CSR bits 22, 23 read zero
// - Device init bit defaults zero
// - Aux current defaults 111b
// - D1 and D2 support default one
// - Wake support defaults 11111b
// - Defaults replaceable by management or boot load
// - Power state field RW, resets D0
// - D3hot to D0 hot reset, no downstream reset
// - No-soft-reset bit skips internal reset
// - Wake enable sticky, drives wake message
// - Wake status reads zero
// - Data byte loadable, data select RW
// - Downstream dword 4Ch id 05h
// - Interrupt capability next pointer 64h
// - Capability list pointer reads 40h
`timescale 1ns/1ps
module port_power_mgmt_capability #(
	parameter bit UPSTREAM = 1'b0,
	parameter int unsigned HOT_RESET_LEN = 4
)
(
	// Clock and resets
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic soft_reset_i,
	// Configuration access
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// Default loading from management port or boot memory
	input wire logic defaults_load_i,
	input wire port_pm_cap_pkg::cap_defaults_s defaults_i,
	// Power state outputs
	output logic [1:0] power_state_o,
	output logic wake_enable_o,
	output logic hot_reset_o,
	output logic internal_reset_o,
	output logic downstream_reset_out_n_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	port_pm_cap_pkg::cap_defaults_s caps;
	port_pm_cap_pkg::cap_defaults_s next_caps;
	logic [1:0] pstate;
	logic [1:0] next_pstate;
	logic wake_en;
	logic next_wake_en;
	logic [3:0] data_sel;
	logic [3:0] next_data_sel;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic rvalid;
	logic next_rvalid;
	logic wake_from_d3;
	logic hot_pulse;
	logic hot_reset;
	logic next_hot_reset;
	logic int_reset;
	logic next_int_reset;
	logic csr_wr;
	logic wr_state;
	logic wr_ctrl;
	logic dn_rst_n;
	logic next_dn_rst_n;

	// Read value of a dword
	function automatic logic [31:0] read_dword(
		input logic [7:0] addr,
		input port_pm_cap_pkg::cap_defaults_s c,
		input logic [1:0] ps,
		input logic we,
		input logic [3:0] ds
	);
		logic [31:0] v;
		v = 32'h00000000;
		case (addr)
			port_pm_cap_pkg::CAP_PTR_OFFSET:
			begin
				v[7:0] = port_pm_cap_pkg::CAP_PTR_RESET;
			end
			port_pm_cap_pkg::PM_CAP_OFFSET:
			begin
				v[7:0] = port_pm_cap_pkg::PM_CAP_ID;
				v[15:8] = UPSTREAM ? port_pm_cap_pkg::PM_NEXT_UP
					: port_pm_cap_pkg::PM_NEXT_DN;
				v[18:16] = port_pm_cap_pkg::PM_REVISION;
				v[19] = 1'b0;
				v[21] = c.dev_init;
				v[24:22] = c.aux_current;
				v[25] = c.d1_support;
				v[26] = c.d2_support;
				v[31:27] = c.wake_support;
			end
			port_pm_cap_pkg::PM_CSR_OFFSET:
			begin
				v[1:0] = ps;
				v[3] = c.no_soft_reset;
				v[8] = we;
				v[12:9] = ds;
				v[15] = 1'b0;
				v[23:22] = 2'h0;
				v[31:24] = c.data_byte;
			end
			port_pm_cap_pkg::MSG_CAP_OFFSET:
			begin
				if (!UPSTREAM)
				begin
					v[7:0] = port_pm_cap_pkg::MSG_CAP_ID;
					v[15:8] = port_pm_cap_pkg::MSG_NEXT;
				end
			end
			default:
			begin
				v = 32'h00000000;
			end
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// Write qualification
	// ------------------------------------------------------------
	// Dropped while a hot reset or soft reset is active
	assign csr_wr = cfg_wr_i && (cfg_addr_i == port_pm_cap_pkg::PM_CSR_OFFSET)
		&& !hot_reset && !soft_reset_i;
	// Byte lanes of the control word
	assign wr_state = csr_wr && cfg_be_i[0];
	assign wr_ctrl = csr_wr && cfg_be_i[1];

	// ------------------------------------------------------------
	// Advertised defaults
	// ------------------------------------------------------------
	always_comb
	begin
		next_caps = caps;
		if (defaults_load_i)
		begin
			next_caps = defaults_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			caps <= port_pm_cap_pkg::CAP_DEFAULTS_RESET;
		end
		else
		begin
			caps <= next_caps;
		end
	end

	// ------------------------------------------------------------
	// Control and status word
	// ------------------------------------------------------------
	always_comb
	begin
		next_pstate = pstate;
		next_data_sel = data_sel;
		next_wake_en = wake_en;
		wake_from_d3 = 1'b0;
		if (soft_reset_i || int_reset)
		begin
			// Hot reset alone keeps the context when no_soft_reset is set
			next_pstate = port_pm_cap_pkg::PSTATE_D0;
			next_data_sel = port_pm_cap_pkg::DATA_SELECT_RESET;
		end
		else
		begin
			if (wr_state)
			begin
				next_pstate = cfg_wdata_i[1:0];
				wake_from_d3 = (pstate == port_pm_cap_pkg::PSTATE_D3HOT)
					&& (cfg_wdata_i[1:0] == port_pm_cap_pkg::PSTATE_D0);
			end
			if (wr_ctrl)
			begin
				next_wake_en = cfg_wdata_i[8];
				next_data_sel = cfg_wdata_i[12:9];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pstate <= port_pm_cap_pkg::PSTATE_D0;
			data_sel <= port_pm_cap_pkg::DATA_SELECT_RESET;
			wake_en <= 1'b0;
		end
		else
		begin
			pstate <= next_pstate;
			data_sel <= next_data_sel;
			wake_en <= next_wake_en;
		end
	end

	// ------------------------------------------------------------
	// Hot reset on wake from D3hot
	// ------------------------------------------------------------
	pm_reset_pulse #(
		.LENGTH(HOT_RESET_LEN)
	) u_hot_pulse (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.start_i(wake_from_d3),
		.pulse_o(hot_pulse)
	);

	always_comb
	begin
		next_hot_reset = hot_pulse;
		next_int_reset = hot_pulse && !caps.no_soft_reset;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			hot_reset <= 1'b0;
			int_reset <= 1'b0;
		end
		else
		begin
			hot_reset <= next_hot_reset;
			int_reset <= next_int_reset;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb
	begin
		next_rvalid = cfg_rd_i;
		next_rdata = rdata;
		if (cfg_rd_i)
		begin
			next_rdata = read_dword(cfg_addr_i, caps, pstate, wake_en, data_sel);
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata <= 32'h00000000;
			rvalid <= 1'b0;
		end
		else
		begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// ------------------------------------------------------------
	// Downstream reset output
	// ------------------------------------------------------------
	always_comb
	begin
		// Never asserted by a power-state hot reset
		next_dn_rst_n = 1'b1;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dn_rst_n <= 1'b1;
		end
		else
		begin
			dn_rst_n <= next_dn_rst_n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cfg_rdata_o = rdata;
	assign cfg_rvalid_o = rvalid;
	assign power_state_o = pstate;
	assign wake_enable_o = wake_en;
	assign hot_reset_o = hot_reset;
	assign internal_reset_o = int_reset;
	assign downstream_reset_out_n_o = dn_rst_n;

endmodule
